// ==== rtl/rrop_result_port.sv ====
// host facing result port: sample capture, parallel and serial readout, pump clock
`timescale 1ns/1ps
`default_nettype none
`include "rrop_defs.svh"
// Contract
// - falling sample strobe copies both integrators
// - select high angle, low speed
// - drivers on only with select and read low
// - respond only while chip select low
// - mode input high serial, low parallel
// - top pin bit eleven or serial out
// - bit ten pin becomes shift clock input
// - bits nine to zero gated three-state
// - read strobe edge frames serial transfer
// - pump output fixed square wave half duty
// - encoder output A driven continuously
// - pump frequency divided from device clock
module rrop_result_port #(
	parameter int PUMP_HALF = `RROP_PUMP_HALF
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic sample_strobe_n,
	input wire logic result_select,
	input wire logic serial_mode_select,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire rrop_pkg::rrop_word_type angle_integ,
	input wire rrop_pkg::rrop_word_type speed_integ,
	input wire logic enc_a_in,
	output logic top_bit_serial_out_o,
	output logic top_bit_serial_out_oe,
	input wire logic bit_ten_shift_clock_i,
	output logic bit_ten_shift_clock_o,
	output logic bit_ten_shift_clock_oe,
	output logic [6:0] result_bits_mid_o,
	output logic result_bits_mid_oe,
	output logic [2:0] result_bits_low_o,
	output logic result_bits_low_oe,
	output logic pump_drive_out,
	output logic enc_a_out
);
	import rrop_pkg::*;

	localparam int PW = $clog2(PUMP_HALF + 1);
	// cycles a pump level stands after its first cycle, for the delay checks
	localparam int PUMP_HOLD = PUMP_HALF - 1;

	// ==========================================
	// pin synchronisers; stage one feeds only stage two
	logic [`RROP_PIN_W-1:0] pin_s1_r;
	logic [`RROP_PIN_W-1:0] pin_s2_r;
	logic [`RROP_PIN_W-1:0] pin_d_r;
	wire logic [`RROP_PIN_W-1:0] pin_raw = {bit_ten_shift_clock_i, read_strobe_n,
		chip_select_n, serial_mode_select, result_select, sample_strobe_n};

	always_ff @(posedge mclk) begin
		if (srst) begin
			pin_s1_r <= `RROP_PIN_RESET;
			pin_s2_r <= `RROP_PIN_RESET;
			pin_d_r <= `RROP_PIN_RESET;
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
			pin_d_r <= pin_s2_r;
		end
	end

	// ==========================================
	// decoded pin levels and edges
	wire logic sample_fall = pin_d_r[`RROP_PIN_SAMPLE] && !pin_s2_r[`RROP_PIN_SAMPLE];
	wire logic sel_angle = pin_s2_r[`RROP_PIN_SEL];
	wire rrop_mode_type mode = pin_s2_r[`RROP_PIN_MODE] ? RROP_SERIAL : RROP_PARALLEL;
	wire logic is_serial = (mode == RROP_SERIAL);
	wire logic cs_act = !pin_s2_r[`RROP_PIN_CS_N];
	wire logic rd_act = !pin_s2_r[`RROP_PIN_RD_N];
	wire logic rd_fall = pin_d_r[`RROP_PIN_RD_N] && rd_act;
	wire logic sclk_fall = pin_d_r[`RROP_PIN_SCLK] && !pin_s2_r[`RROP_PIN_SCLK];
	wire logic out_en = cs_act && rd_act;

	// ==========================================
	// result registers: only a sample edge changes them
	rrop_word_type angle_r;
	rrop_word_type speed_r;

	always_ff @(posedge mclk) begin
		if (srst) begin
			angle_r <= `RROP_WORD_RESET;
			speed_r <= `RROP_WORD_RESET;
		end else if (sample_fall) begin
			angle_r <= angle_integ;
			speed_r <= speed_integ;
		end
	end

	wire rrop_word_type sel_word = sel_angle ? angle_r : speed_r;

	// ==========================================
	// serial shifter; host samples on rising, we move on falling
	rrop_shift_if sh ();
	assign sh.load = rd_fall && cs_act && is_serial;
	assign sh.advance = sclk_fall && cs_act && rd_act && is_serial;
	assign sh.word = sel_word;

	rrop_shifter u_shifter (
		.mclk(mclk),
		.srst(srst),
		.sh(sh.shifter)
	);

	// ==========================================
	// pin drive registers, next values decoded here
	wire logic top_nxt = is_serial ? sh.bit_out : sel_word[`RROP_TOP_BIT];
	wire logic ten_oe_nxt = out_en && !is_serial;

	always_ff @(posedge mclk) begin
		if (srst) begin
			top_bit_serial_out_o <= 1'b0;
			top_bit_serial_out_oe <= 1'b0;
			bit_ten_shift_clock_o <= 1'b0;
			bit_ten_shift_clock_oe <= 1'b0;
			result_bits_mid_o <= 7'h00;
			result_bits_mid_oe <= 1'b0;
			result_bits_low_o <= 3'h0;
			result_bits_low_oe <= 1'b0;
		end else begin
			top_bit_serial_out_o <= top_nxt;
			top_bit_serial_out_oe <= out_en;
			bit_ten_shift_clock_o <= sel_word[`RROP_TEN_BIT];
			bit_ten_shift_clock_oe <= ten_oe_nxt;
			result_bits_mid_o <= sel_word[`RROP_MID_HI:`RROP_MID_LO];
			result_bits_mid_oe <= out_en;
			result_bits_low_o <= sel_word[`RROP_LOW_HI:`RROP_LOW_LO];
			result_bits_low_oe <= out_en;
		end
	end

	// ==========================================
	// charge pump: fixed ratio of the device clock, so it
	// scales with whatever clock the system supplies
	logic [PW-1:0] pump_cnt_r;
	wire logic pump_wrap = (pump_cnt_r == PW'(PUMP_HALF - 1));

	always_ff @(posedge mclk) begin
		if (srst) begin
			pump_cnt_r <= '0;
			pump_drive_out <= 1'b0;
		end else begin
			pump_cnt_r <= pump_wrap ? '0 : pump_cnt_r + PW'(1);
			pump_drive_out <= pump_wrap ? !pump_drive_out : pump_drive_out;
		end
	end

	// ==========================================
	// encoder output A: free running, no host involvement
	always_ff @(posedge mclk) begin
		if (srst) begin
			enc_a_out <= 1'b0;
		end else begin
			enc_a_out <= enc_a_in;
		end
	end

	// ==========================================
	// checks
	a_sample_copies_both:
	assert property (@(posedge mclk) disable iff (srst)
		sample_fall |=> (angle_r == $past(angle_integ)) && (speed_r == $past(speed_integ)))
		else $error("sample edge did not capture integrators");
	a_results_hold:
	assert property (@(posedge mclk) disable iff (srst)
		!sample_fall |=> $stable(angle_r) && $stable(speed_r))
		else $error("result changed without a sample edge");
	a_select_angle_word:
	assert property (@(posedge mclk) disable iff (srst)
		(sel_angle && !is_serial && !sample_fall) |=> result_bits_mid_o == angle_r[9:3])
		else $error("select high did not present angle");
	a_drivers_gated:
	assert property (@(posedge mclk) disable iff (srst)
		(pin_s2_r[`RROP_PIN_CS_N] || pin_s2_r[`RROP_PIN_RD_N]) |=>
		!top_bit_serial_out_oe && !result_bits_mid_oe && !result_bits_low_oe &&
		!bit_ten_shift_clock_oe)
		else $error("driver enabled without chip select and read");
	a_pin_to_enable:
	assert property (@(posedge mclk) disable iff (srst)
		($fell(pin_s2_r[`RROP_PIN_CS_N]) && !pin_s2_r[`RROP_PIN_RD_N])
		|=> result_bits_mid_oe && result_bits_low_oe)
		else $error("low bits not enabled after chip select");
	a_ten_is_input:
	assert property (@(posedge mclk) disable iff (srst)
		is_serial |=> !bit_ten_shift_clock_oe)
		else $error("shift clock pin driven in serial mode");
	a_serial_msb_out:
	assert property (@(posedge mclk) disable iff (srst)
		sh.load ##1 is_serial |=> top_bit_serial_out_o == $past(sh.word[11], 2))
		else $error("serial frame did not start with msb");
	a_pump_half_period:
	assert property (@(posedge mclk) disable iff (srst)
		$rose(pump_drive_out) |-> ##PUMP_HOLD pump_drive_out ##1 !pump_drive_out)
		else $error("pump half period wrong");
	a_enc_follows:
	assert property (@(posedge mclk) disable iff (srst)
		##1 enc_a_out == $past(enc_a_in))
		else $error("encoder output not following");
	a_top_follows_word:
	assert property (@(posedge mclk) disable iff (srst)
		!is_serial |=> top_bit_serial_out_o == $past(sel_word[`RROP_TOP_BIT]))
		else $error("top pin not showing bit eleven in parallel mode");
	a_ten_follows_word:
	assert property (@(posedge mclk) disable iff (srst)
		!is_serial |=> bit_ten_shift_clock_o == $past(sel_word[`RROP_TEN_BIT]))
		else $error("bit ten pin not showing bit ten in parallel mode");
	a_low_bits_follow:
	assert property (@(posedge mclk) disable iff (srst)
		out_en |=> result_bits_low_o == $past(sel_word[`RROP_LOW_HI:`RROP_LOW_LO]))
		else $error("low pins not showing the selected word");
	a_select_speed_word:
	assert property (@(posedge mclk) disable iff (srst)
		(!sel_angle && !sample_fall) |=> result_bits_mid_o == speed_r[9:3])
		else $error("select low did not present speed");
	a_shift_needs_frame:
	assert property (@(posedge mclk) disable iff (srst)
		(!cs_act || !rd_act) |=> $stable(sh.bit_out))
		else $error("serial output moved outside a read frame");
	a_pump_low_half:
	assert property (@(posedge mclk) disable iff (srst)
		$fell(pump_drive_out) |-> ##PUMP_HOLD !pump_drive_out ##1 pump_drive_out)
		else $error("pump low half period wrong");
endmodule
`default_nettype wire

// ==== rtl/rrop_defs.svh ====
// bit positions, reset values and timing counts for the result output port
`ifndef RROP_DEFS_SVH
`define RROP_DEFS_SVH

// ==========================================
// word layout
`define RROP_WORD_W 12
`define RROP_TOP_BIT 11
`define RROP_TEN_BIT 10
`define RROP_MID_HI 9
`define RROP_MID_LO 3
`define RROP_LOW_HI 2
`define RROP_LOW_LO 0
`define RROP_LAST_SHIFT 4'hB
`define RROP_WORD_RESET 12'h000

// ==========================================
// synchronised pin vector positions
`define RROP_PIN_W 6
`define RROP_PIN_SAMPLE 0
`define RROP_PIN_SEL 1
`define RROP_PIN_MODE 2
`define RROP_PIN_CS_N 3
`define RROP_PIN_RD_N 4
`define RROP_PIN_SCLK 5
`define RROP_PIN_RESET 6'h3F

// ==========================================
// charge pump timing
`define RROP_CRYSTAL_HZ 8192000
`define RROP_PUMP_HZ 204800
`define RROP_PUMP_HALF ((`RROP_CRYSTAL_HZ) / (2 * `RROP_PUMP_HZ))

`endif

// ==== rtl/rrop_pkg.sv ====
// types shared by the result output port modules
package rrop_pkg;
	typedef logic [11:0] rrop_word_type;
	typedef enum logic [1:0] {
		RROP_PARALLEL = 2'b01,
		RROP_SERIAL = 2'b10
	} rrop_mode_type;
endpackage

// ==== rtl/rrop_shift_if.sv ====
// link between the port control and the serial shifter
`timescale 1ns/1ps
`default_nettype none
interface rrop_shift_if;
	import rrop_pkg::*;
	logic load;
	logic advance;
	rrop_word_type word;
	logic bit_out;
	logic done;
	modport ctrl (output load, output advance, output word, input bit_out, input done);
	modport shifter (input load, input advance, input word, output bit_out, output done);
endinterface
`default_nettype wire

// ==== rtl/rrop_shifter.sv ====
// serial shifter for the selected result word
`timescale 1ns/1ps
`default_nettype none
`include "rrop_defs.svh"
module rrop_shifter (
	input wire logic mclk,
	input wire logic srst,
	rrop_shift_if.shifter sh
);
	import rrop_pkg::*;

	rrop_word_type shift_r;
	logic [3:0] cnt_r;
	wire logic at_end = (cnt_r == `RROP_LAST_SHIFT);

	// ==========================================
	// msb first, one bit per host clock; holds after the last bit
	always_ff @(posedge mclk) begin
		if (srst) begin
			shift_r <= `RROP_WORD_RESET;
			cnt_r <= 4'h0;
		end else if (sh.load) begin
			shift_r <= sh.word;
			cnt_r <= 4'h0;
		end else if (sh.advance && !at_end) begin
			shift_r <= {shift_r[10:0], 1'b0};
			cnt_r <= cnt_r + 4'h1;
		end
	end

	assign sh.bit_out = shift_r[`RROP_TOP_BIT];
	assign sh.done = at_end;

	// ==========================================
	// checks
	a_load_msb_first:
	assert property (@(posedge mclk) disable iff (srst)
		sh.load |=> (sh.bit_out == $past(sh.word[11])) && (cnt_r == 4'h0))
		else $error("shifter did not start at the msb");
	a_stop_after_twelve:
	assert property (@(posedge mclk) disable iff (srst)
		(at_end && !sh.load) |=> $stable(shift_r) && $stable(cnt_r))
		else $error("shifter ran past the last bit");
endmodule
`default_nettype wire

// ==== tb/rrop_host_model.sv ====
// host model: drives chip select, read strobe and shift clock, reads the result pins
`timescale 1ns/1ps
`default_nettype none
module rrop_host_model (
	input wire logic mclk,
	input wire logic [11:0] pins,
	input wire logic [3:0] oes,
	output logic cs_n,
	output logic rd_n,
	output logic sclk
);
	// ==========================================
	// idle: deselected, shift clock parked high
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		sclk = 1'b1;
	end
	// strobe low, wait out the pin sync, then grab pins and enables
	task automatic open_read(input logic cs, output logic [11:0] w, output logic [3:0] e);
		@(posedge mclk);
		cs_n <= cs;
		rd_n <= 1'b0;
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		w = pins;
		e = oes;
	endtask
	// release both strobes and let the enables fall away
	task automatic close_read();
		@(posedge mclk);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (5) @(posedge mclk);
	endtask
	// eleven falling shift clocks, each bit taken just before the rise
	task automatic shift_rest(inout logic [11:0] w);
		for (int i = 10; i >= 0; i--) begin
			@(posedge mclk);
			sclk <= 1'b0;
			repeat (5) @(posedge mclk);
			@(negedge mclk);
			w[i] = pins[11];
			@(posedge mclk);
			sclk <= 1'b1;
			repeat (3) @(posedge mclk);
		end
	endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the result output port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rrop_pkg::*;
	logic mclk = 1'b0, srst = 1'b1, sample_n = 1'b1, sel = 1'b1, mode = 1'b0, enc_in = 1'b0;
	rrop_word_type angle = 12'h000, speed = 12'h000;
	logic cs_n, rd_n, sclk, top_o, top_oe, ten_o, ten_oe, mid_oe, low_oe, pump, enc_out;
	logic [6:0] mid_o;
	logic [2:0] low_o;
	logic [11:0] w;
	logic [3:0] e;
	int error_cnt = 0, tests_run = 0, cycles = 0;
	wire logic ten_pin;
	wire logic [11:0] pins;
	wire logic [3:0] oes;
	// ==========================================
	// pin resolution; a released pin shows the inverse of its last level,
	// so a missing enable reads back wrong
	assign ten_pin = ten_oe ? ten_o : (mode ? sclk : ~ten_o);
	assign pins = {top_oe ? top_o : ~top_o, ten_oe ? ten_o : ~ten_o,
		mid_oe ? mid_o : ~mid_o, low_oe ? low_o : ~low_o};
	assign oes = {top_oe, ten_oe, mid_oe, low_oe};
	// bench clock; result accuracy against the crystal rate lies outside this block
	always #25 mclk = ~mclk;
	// short pump count keeps the duty check quick
	rrop_result_port #(.PUMP_HALF(2)) DUT (.mclk(mclk), .srst(srst), .sample_strobe_n(sample_n),
		.result_select(sel), .serial_mode_select(mode), .chip_select_n(cs_n),
		.read_strobe_n(rd_n), .angle_integ(angle), .speed_integ(speed), .enc_a_in(enc_in),
		.top_bit_serial_out_o(top_o), .top_bit_serial_out_oe(top_oe),
		.bit_ten_shift_clock_i(ten_pin), .bit_ten_shift_clock_o(ten_o),
		.bit_ten_shift_clock_oe(ten_oe), .result_bits_mid_o(mid_o), .result_bits_mid_oe(mid_oe),
		.result_bits_low_o(low_o), .result_bits_low_oe(low_oe), .pump_drive_out(pump),
		.enc_a_out(enc_out));
	rrop_host_model host (.mclk(mclk), .pins(pins), .oes(oes), .cs_n(cs_n), .rd_n(rd_n),
		.sclk(sclk));
	// ==========================================
	// checking and closing
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// hang guard, well above the few hundred cycles the tests need
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	// ==========================================
	// scenarios
	// integrators change after the strobe to prove the snapshot holds
	task automatic capture(input rrop_word_type a, input rrop_word_type s);
		@(posedge mclk);
		angle <= a;
		speed <= s;
		sample_n <= 1'b0;
		repeat (3) @(posedge mclk);
		sample_n <= 1'b1;
		repeat (3) @(posedge mclk);
		angle <= ~a;
		speed <= ~s;
	endtask
	task automatic t_par(input logic s, input rrop_word_type exp);
		@(posedge mclk);
		sel <= s;
		mode <= 1'b0;
		repeat (3) @(posedge mclk);
		host.open_read(1'b0, w, e);
		check(w, exp);
		check({8'h00, e}, 12'h00F);
		host.close_read();
		@(negedge mclk);
		check({8'h00, oes}, 12'h000);
		$display("done parallel read");
	endtask
	task automatic t_refuse();
		host.open_read(1'b1, w, e);
		check({8'h00, e}, 12'h000);
		host.close_read();
		$display("done deselected read");
	endtask
	task automatic t_ser(input logic s, input rrop_word_type exp);
		@(posedge mclk);
		sel <= s;
		mode <= 1'b1;
		repeat (4) @(posedge mclk);
		host.open_read(1'b0, w, e);
		check({8'h00, e}, 12'h00B);
		host.shift_rest(w);
		check(w, exp);
		host.close_read();
		$display("done serial read");
	endtask
	// pump counted over 40 cycles; encoder follows one cycle late
	task automatic t_pump();
		int hi, flips;
		logic last;
		hi = 0;
		flips = 0;
		last = pump;
		for (int i = 0; i < 40; i++) begin
			@(posedge mclk);
			enc_in <= i[0];
			@(negedge mclk);
			hi += int'(pump);
			flips += int'(pump != last);
			last = pump;
			if (i > 0) check({11'h000, enc_out}, {11'h000, ~i[0]});
		end
		check(hi[11:0], 12'h014);
		check(flips[11:0], 12'h014);
		$display("done pump and encoder");
	endtask
	// ==========================================
	// main sequence
	initial begin
		@(posedge mclk);
		@(negedge mclk);
		check({4'h0, pump, enc_out, top_oe, ten_oe, mid_oe, low_oe, top_o, ten_o}, 12'h000);
		@(posedge mclk);
		srst <= 1'b0;
		$display("done reset");
		capture(12'hA5C, 12'h3B1);
		t_par(1'b1, 12'hA5C);
		t_par(1'b0, 12'h3B1);
		t_refuse();
		t_ser(1'b1, 12'hA5C);
		t_ser(1'b0, 12'h3B1);
		capture(12'h800, 12'h001);
		t_par(1'b1, 12'h800);
		t_pump();
		report_and_stop();
	end
endmodule
`default_nettype wire
